// *** rtl/rwdt_pkg.sv ***
/*
 * Package for the real-time clock watchdog: register indices, field
 * positions, reset values, clock rates and the shared types.
 * Assumes a single 40 MHz system clock and a 32-bit APB register bus.
 */
package rwdt_pkg;

  // Clock rates
  localparam int CLK_HZ        = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_HZ        = 32_768;
  localparam int ACC_W         = 26;
  localparam int PRE_W         = 17;

  // Prescaler roll masks, one per step select (0.25 Hz, 1 Hz, 4 Hz, 16 Hz)
  localparam logic [PRE_W-1:0] TAP_4S  = 17'h1ffff;
  localparam logic [PRE_W-1:0] TAP_1S  = 17'h07fff;
  localparam logic [PRE_W-1:0] TAP_Q   = 17'h01fff;
  localparam logic [PRE_W-1:0] TAP_16  = 17'h007ff;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_INT_FIRST_EN  = 8'h29;
  localparam logic [7:0] IDX_INT_SECOND_EN = 8'h2a;
  localparam logic [7:0] IDX_WD_CTRL       = 8'h2d;
  localparam logic [7:0] IDX_IRQ_STATUS    = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK      = 8'h31;
  localparam logic [7:0] IDX_IRQ_MODE      = 8'h32;
  localparam int         ADDR_W            = 10;

  // Control register field positions
  localparam int CTRL_REPEAT_BIT = 7;
  localparam int CTRL_LOAD_LSB   = 2;
  localparam int CTRL_LOAD_MSB   = 6;
  localparam int CTRL_STEP_LSB   = 0;
  localparam int CTRL_STEP_MSB   = 1;

  // Single-bit fields in the enable, status, mask and mode registers
  localparam int EN_WD_BIT         = 0;
  localparam int STAT_EXPIRY_BIT   = 0;
  localparam int MODE_PULSE_FIRST  = 0;
  localparam int MODE_PULSE_SECOND = 1;

  // Reset values
  localparam logic [7:0] RST_WD_CTRL = 8'h00;
  localparam logic       RST_BIT     = 1'b0;
  localparam logic [4:0] COUNT_ZERO  = 5'h00;
  localparam logic [4:0] COUNT_ONE   = 5'h01;

  // Step select encodings
  localparam logic [1:0] STEP_4S  = 2'h0;
  localparam logic [1:0] STEP_1S  = 2'h1;
  localparam logic [1:0] STEP_Q   = 2'h2;
  localparam logic [1:0] STEP_16  = 2'h3;

  typedef struct packed {
    logic       repeat_select;
    logic [4:0] countdown_load;
    logic [1:0] step_select;
  } rwdt_ctrl_t;

  typedef struct packed {
    logic       valid;
    rwdt_ctrl_t ctrl;
  } rwdt_load_t;

  typedef enum logic [1:0] {
    RWDT_STOP = 2'b01,
    RWDT_RUN  = 2'b10
  } rwdt_state_t;

endpackage

// *** rtl/rwdt_top.sv ***
/*
 * Watchdog countdown timer of a real-time clock, with an APB register
 * slave, a derived 32.768 kHz time base, two gated interrupt outputs and
 * one masked summary interrupt.
 * Assumes an APB master on the same 40 MHz clock and a synchronous,
 * active-high reset.
 */
// Local design decision: register access over APB.
// Summary of operation
// - Five-bit load in bits 6:2, counts down.
// - Load of zero halts the countdown.
// - Nonzero load starts countdown at once.
// - Bits 1:0 pick 4 s, 1 s, 1/4 s, 1/16 s.
// - Period equals load times step.
// - New load replaces running count immediately.
// - First period may be one count short.
// - Reads return live count, not written value.
// - Repeat mode flags, reloads, restarts each period.
// - Flag stays set until host clears it.
// - Single shot flags and stops at zero.
// - Separate enable bit per interrupt output.
// - Output pulses per expiry or mirrors flag.
// - Pulse repeats even while flag stays set.
// - Steps derive from 32.768 kHz time base.
`timescale 1ns/1ps
module rwdt_top (
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [rwdt_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  input  wire logic [3:0]                 pstrb_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  output logic                            irq_out_first_o,
  output logic                            irq_out_second_o,
  output logic                            irq_o
);
  import rwdt_pkg::*;

  // Bus decode
  logic        setup_phase;
  logic        access_phase;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  reg_idx;
  logic        addr_ok;
  logic        aligned;
  logic        lane0;

  assign setup_phase  = psel_i && !penable_i;
  assign access_phase = psel_i && penable_i;
  assign reg_idx      = paddr_i[ADDR_W-1:2];
  assign aligned      = (paddr_i[1:0] == 2'h0);
  assign addr_ok      = aligned &&
                        ((reg_idx == IDX_INT_FIRST_EN)  ||
                         (reg_idx == IDX_INT_SECOND_EN) ||
                         (reg_idx == IDX_WD_CTRL)       ||
                         (reg_idx == IDX_IRQ_STATUS)    ||
                         (reg_idx == IDX_IRQ_MASK)      ||
                         (reg_idx == IDX_IRQ_MODE));
  assign lane0        = pstrb_i[0];
  assign wr_en        = access_phase && pwrite_i && addr_ok && lane0;
  assign rd_en        = access_phase && !pwrite_i && addr_ok;

  // Every access completes after one wait-free access phase
  assign pready_o  = access_phase;
  assign pslverr_o = access_phase && !addr_ok;

  // Software-visible registers
  rwdt_ctrl_t  ctrl_q;
  logic        en_first_q;
  logic        en_second_q;
  logic        flag_q;
  logic        mask_q;
  logic        pulse_first_q;
  logic        pulse_second_q;

  // Watchdog core state
  rwdt_load_t  stage_q;
  rwdt_state_t state_q;
  logic [4:0]  count_q;
  logic        expire_q;

  // Time base
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W:0]   acc_sum;
  logic             osc_tick;
  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] tap_mask;
  logic             step_tick;
  logic             expire_now;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_q <= rwdt_ctrl_t'(RST_WD_CTRL);
    end else if (wr_en && reg_idx == IDX_WD_CTRL) begin
      ctrl_q.repeat_select  <= pwdata_i[CTRL_REPEAT_BIT];
      ctrl_q.countdown_load <= pwdata_i[CTRL_LOAD_MSB:CTRL_LOAD_LSB];
      ctrl_q.step_select    <= pwdata_i[CTRL_STEP_MSB:CTRL_STEP_LSB];
    end
  end

  // Settings are moved into the counter as one word with a valid strobe,
  // so the counter never sees a half-written mix of old and new fields
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stage_q <= '0;
    end else begin
      stage_q.valid              <= wr_en && (reg_idx == IDX_WD_CTRL);
      stage_q.ctrl.repeat_select  <= pwdata_i[CTRL_REPEAT_BIT];
      stage_q.ctrl.countdown_load <= pwdata_i[CTRL_LOAD_MSB:CTRL_LOAD_LSB];
      stage_q.ctrl.step_select    <= pwdata_i[CTRL_STEP_MSB:CTRL_STEP_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      en_first_q  <= RST_BIT;
      en_second_q <= RST_BIT;
    end else begin
      if (wr_en && reg_idx == IDX_INT_FIRST_EN) begin
        en_first_q <= pwdata_i[EN_WD_BIT];
      end
      if (wr_en && reg_idx == IDX_INT_SECOND_EN) begin
        en_second_q <= pwdata_i[EN_WD_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mask_q         <= RST_BIT;
      pulse_first_q  <= RST_BIT;
      pulse_second_q <= RST_BIT;
    end else begin
      if (wr_en && reg_idx == IDX_IRQ_MASK) begin
        mask_q <= pwdata_i[STAT_EXPIRY_BIT];
      end
      if (wr_en && reg_idx == IDX_IRQ_MODE) begin
        pulse_first_q  <= pwdata_i[MODE_PULSE_FIRST];
        pulse_second_q <= pwdata_i[MODE_PULSE_SECOND];
      end
    end
  end

  // 32.768 kHz ticks from the 40 MHz clock by a phase accumulator; the
  // tick spacing jitters by one clock, which stands in for the effect
  // of oscillator correction on individual periods
  assign acc_sum  = {1'b0, acc_q} + (ACC_W+1)'(OSC_HZ);
  assign osc_tick = (acc_sum >= (ACC_W+1)'(CLK_HZ));

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_q <= '0;
    end else if (osc_tick) begin
      acc_q <= ACC_W'(acc_sum - (ACC_W+1)'(CLK_HZ));
    end else begin
      acc_q <= acc_sum[ACC_W-1:0];
    end
  end

  // Free-running prescaler; a load does not restart it, so the first
  // step after a write may come early by up to one step
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pre_q <= '0;
    end else if (osc_tick) begin
      pre_q <= pre_q + PRE_W'(1);
    end
  end

  always_comb begin
    case (ctrl_q.step_select)
      STEP_4S: tap_mask = TAP_4S;
      STEP_1S: tap_mask = TAP_1S;
      STEP_Q:  tap_mask = TAP_Q;
      STEP_16: tap_mask = TAP_16;
      default: tap_mask = TAP_4S;
    endcase
  end

  assign step_tick  = osc_tick && ((pre_q & tap_mask) == tap_mask);
  assign expire_now = (state_q == RWDT_RUN) && step_tick && (count_q == COUNT_ONE);

  // Countdown: a staged write always wins over a step
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_q <= COUNT_ZERO;
      state_q <= RWDT_STOP;
    end else if (stage_q.valid) begin
      count_q <= stage_q.ctrl.countdown_load;
      if (stage_q.ctrl.countdown_load == COUNT_ZERO) begin
        state_q <= RWDT_STOP;
      end else begin
        state_q <= RWDT_RUN;
      end
    end else begin
      case (state_q)
        RWDT_STOP: begin
          state_q <= RWDT_STOP;
        end
        RWDT_RUN: begin
          if (expire_now && ctrl_q.repeat_select) begin
            count_q <= ctrl_q.countdown_load;
          end else if (expire_now) begin
            count_q <= COUNT_ZERO;
            state_q <= RWDT_STOP;
          end else if (step_tick) begin
            count_q <= count_q - COUNT_ONE;
          end
        end
        default: begin
          state_q <= RWDT_STOP;
          count_q <= COUNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      expire_q <= 1'b0;
    end else begin
      expire_q <= expire_now;
    end
  end

  // Sticky expiry flag; reading the status register is the clear
  // command, and an expiry in that same cycle keeps the flag set
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flag_q <= RST_BIT;
    end else if (expire_q) begin
      flag_q <= 1'b1;
    end else if (rd_en && reg_idx == IDX_IRQ_STATUS) begin
      flag_q <= 1'b0;
    end
  end

  // Interrupt outputs are registered so they never glitch
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_out_first_o  <= 1'b0;
      irq_out_second_o <= 1'b0;
      irq_o            <= 1'b0;
    end else begin
      irq_out_first_o  <= en_first_q &&
                          (pulse_first_q ? expire_q : (flag_q || expire_q));
      irq_out_second_o <= en_second_q &&
                          (pulse_second_q ? expire_q : (flag_q || expire_q));
      irq_o            <= mask_q && (flag_q || expire_q);
    end
  end

  // Read data is captured in the setup cycle and held for the access
  // phase; the count may move between two reads, so software compares
  // two readings
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prdata_o <= '0;
    end else if (setup_phase && !pwrite_i) begin
      prdata_o <= '0;
      if (aligned) begin
        case (reg_idx)
          IDX_WD_CTRL: begin
            prdata_o[CTRL_REPEAT_BIT]               <= ctrl_q.repeat_select;
            prdata_o[CTRL_LOAD_MSB:CTRL_LOAD_LSB]   <= count_q;
            prdata_o[CTRL_STEP_MSB:CTRL_STEP_LSB]   <= ctrl_q.step_select;
          end
          IDX_INT_FIRST_EN:  prdata_o[EN_WD_BIT]       <= en_first_q;
          IDX_INT_SECOND_EN: prdata_o[EN_WD_BIT]       <= en_second_q;
          IDX_IRQ_STATUS:    prdata_o[STAT_EXPIRY_BIT] <= flag_q;
          IDX_IRQ_MASK:      prdata_o[STAT_EXPIRY_BIT] <= mask_q;
          IDX_IRQ_MODE: begin
            prdata_o[MODE_PULSE_FIRST]  <= pulse_first_q;
            prdata_o[MODE_PULSE_SECOND] <= pulse_second_q;
          end
          default: prdata_o <= '0;
        endcase
      end
    end
  end

endmodule

// *** verification/rwdt_chk.sv ***
/* Checker for the watchdog top: bus answer and interrupt relations.
   Assumes it is bound to rwdt_top, one clock, synchronous reset. */
`timescale 1ns/1ps
module rwdt_chk (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [9:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        irq_out_first_o,
  input wire logic        irq_out_second_o,
  input wire logic        irq_o
);
  logic acc;
  logic rd;
  assign acc = psel_i && penable_i;
  assign rd  = acc && !pwrite_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_ready; acc |-> pready_o; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_idle; !psel_i |-> !pready_o && !pslverr_o; endproperty
  a_idle: assert property (p_idle) else $error("answer while idle");
  property p_unalign; acc && paddr_i[1:0] != 2'h0 |-> pslverr_o; endproperty
  a_unalign: assert property (p_unalign) else $error("unaligned not refused");
  property p_ctrl_ok; acc && paddr_i == 10'h0b4 |-> pready_o && !pslverr_o; endproperty
  a_ctrl_ok: assert property (p_ctrl_ok) else $error("control access refused");
  property p_ctrl_w; rd && paddr_i == 10'h0b4 |-> prdata_o[31:8] == 24'h0; endproperty
  a_ctrl_w: assert property (p_ctrl_w) else $error("control read too wide");
  property p_en_w;
    rd && (paddr_i == 10'h0a4 || paddr_i == 10'h0a8) |-> prdata_o[31:1] == 31'h0;
  endproperty
  a_en_w: assert property (p_en_w) else $error("enable read too wide");
  property p_unmap; rd && paddr_i == 10'h0b0 |-> pslverr_o && prdata_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  property p_sticky; $fell(irq_o) |-> $past(acc) || $past(acc, 2); endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped alone");
  property p_pulse;
    $fell(irq_out_first_o) && !$past(acc) && !$past(acc, 2) |-> !$past(irq_out_first_o, 2);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse longer than one");
  c_ctrl_wr: cover property (acc && pwrite_i && paddr_i == 10'h0b4);
  c_err: cover property (acc && pslverr_o);
  c_stat: cover property (rd && paddr_i == 10'h0c0);
endmodule

bind rwdt_top rwdt_chk rwdt_chk_inst (
  .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .irq_out_first_o(irq_out_first_o),
  .irq_out_second_o(irq_out_second_o), .irq_o(irq_o)
);

// *** verification/rwdt_host.sv ***
/* Host model: APB master tasks standing for the host software.
   Assumes the watchdog bench as top, which owns the failure count. */
`timescale 1ns/1ps
module rwdt_host (
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic [31:0] prdata_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [9:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  output logic [3:0]       pstrb_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 10'h0;
    pwdata_o = 32'h0;
    pstrb_o = 4'h0;
  end

  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] wd,
                      input logic [3:0] st, output logic [31:0] rdat, output logic er);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= wd;
    pstrb_o <= st;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 16);
    rdat = prdata_i;
    er = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    if (n >= 16) begin
      rwdt_top_tb.n_fail++;
      rwdt_top_tb.test_done();
    end
  endtask

  // The count cannot be frozen, so reread until two reads agree, keeping the last read after three retries
  task automatic rd2(input logic [9:0] a, output logic [31:0] d, output logic er);
    logic [31:0] p;
    xfer(1'b0, a, 32'h0, 4'h0, p, er);
    xfer(1'b0, a, 32'h0, 4'h0, d, er);
    for (int i = 0; i < 3 && d !== p; i++) begin
      p = d;
      xfer(1'b0, a, 32'h0, 4'h0, d, er);
    end
  endtask
endmodule

// *** verification/rwdt_top_tb.sv ***
/* Bench for the watchdog top: register behaviour over APB.
   Assumes the 40 MHz clock; a step lasts millions of cycles, so expiry
   itself is left to the checker and is not reached in this run. */
`timescale 1ns/1ps
module rwdt_top_tb;
  import rwdt_pkg::*;
  logic        clk_i;
  logic        reset_i;
  logic        psel, penable, pwrite, pready, pslverr, irq_a, irq_b, irq;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0]  pstrb;
  logic        e;
  int          n_fail, total_checks;

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  rwdt_host rwdt_host_inst (.clk_i(clk_i), .pready_i(pready), .pslverr_i(pslverr),
    .prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb));
  rwdt_top rwdt_top_inst (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .irq_out_first_o(irq_a), .irq_out_second_o(irq_b), .irq_o(irq));

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [9:0] ba(input logic [7:0] idx);
    return {idx, 2'h0};
  endfunction

  task automatic wr(input logic [7:0] idx, input logic [7:0] v, input logic [3:0] st);
    rwdt_host_inst.xfer(1'b1, ba(idx), {24'h0, v}, st, d, e);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] v);
    rwdt_host_inst.rd2(ba(idx), d, e);
    chk({e, d}, {1'b0, 24'h0, v});
  endtask

  task automatic t_defaults();
    rdc(IDX_WD_CTRL, RST_WD_CTRL);
    rdc(IDX_IRQ_STATUS, 8'h00);
    chk({30'h0, irq_a, irq_b, irq}, 33'h0);
  endtask

  task automatic t_steps();
    for (int s = 0; s < 4; s++) begin
      wr(IDX_WD_CTRL, {1'b0, COUNT_ONE, s[1:0]}, 4'hf);
      rdc(IDX_WD_CTRL, {1'b0, COUNT_ONE, s[1:0]});
    end
  endtask

  task automatic t_reload();
    wr(IDX_WD_CTRL, {1'b1, 5'h1f, STEP_16}, 4'hf);
    rdc(IDX_WD_CTRL, 8'hff);
    wr(IDX_WD_CTRL, {1'b1, 5'h05, STEP_Q}, 4'hf);
    rdc(IDX_WD_CTRL, 8'h96);
  endtask

  task automatic t_stop();
    wr(IDX_WD_CTRL, {1'b1, COUNT_ZERO, STEP_16}, 4'hf);
    repeat (200) @(posedge clk_i);
    rdc(IDX_WD_CTRL, 8'h83);
    rdc(IDX_IRQ_STATUS, 8'h00);
  endtask

  task automatic t_irq();
    wr(IDX_INT_FIRST_EN, 8'h01, 4'hf);
    wr(IDX_INT_SECOND_EN, 8'h01, 4'hf);
    wr(IDX_IRQ_MODE, 8'h03, 4'hf);
    wr(IDX_IRQ_MASK, 8'h01, 4'hf);
    rdc(IDX_INT_FIRST_EN, 8'h01);
    rdc(IDX_INT_SECOND_EN, 8'h01);
    rdc(IDX_IRQ_MODE, 8'h03);
    rdc(IDX_IRQ_MASK, 8'h01);
    chk({30'h0, irq_a, irq_b, irq}, 33'h0);
  endtask

  task automatic t_refuse();
    wr(IDX_WD_CTRL, 8'h7c, 4'he);
    rdc(IDX_WD_CTRL, 8'h83);
    rwdt_host_inst.xfer(1'b0, ba(IDX_WD_CTRL) + 10'h1, 32'h0, 4'h0, d, e);
    chk({e, d}, {1'b1, 32'h0});
    rwdt_host_inst.xfer(1'b1, ba(8'h2c), 32'h55, 4'hf, d, e);
    chk({32'h0, e}, 33'h1);
  endtask

  initial begin
    n_fail = 0;
    total_checks = 0;
    reset_i = 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    t_defaults();
    t_steps();
    t_reload();
    t_stop();
    t_irq();
    t_refuse();
    test_done();
  end
endmodule
